// File: hdl/nvram_host.sv
// host controller driving a latched-address parallel nonvolatile memory
//
// Overview of operation
// - host may move address after hold time; operation unaffected.
// - host holds write data stable for setup before write end.
// - writes finish in the bus cycle; next access may follow at once.
// - host keeps select high for minimum precharge between cycles.
// - host never keeps select low beyond maximum active time.
// - host gives a fresh select fall for every access.
// - no supply blocking in device; host inhibits access when supply bad.
// - select active at least 70 ns and at most 2000 ns.
// - strobe-controlled write holds strobe low at least 40 ns.
`timescale 1ns/100ps
module nvram_host
  import nvram_host_pkg::*;
#(
  parameter bit WE_CONTROLLED = 1'b1
) (
  input  wire logic                           clk_i,
  input  wire logic                           srst_i,
  input  wire logic                           supply_ok_i,
  input  wire logic                           req_valid_i,
  input  wire logic                           req_write_i,
  input  wire logic [nvram_host_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [nvram_host_pkg::DATA_W-1:0] req_wdata_i,
  output      logic                           req_ready_o,
  output      logic                           rsp_valid_o,
  output      logic [nvram_host_pkg::DATA_W-1:0] rsp_rdata_o,
  output      logic [nvram_host_pkg::BLOCK_BITS-1:0] rsp_block_o,
  output      logic [15:0]                    rsp_row_wear_o,
  output      logic                           chip_sel_n_o,
  output      logic                           write_strobe_n_o,
  output      logic                           out_drive_n_o,
  output      logic [nvram_host_pkg::ADDR_W-1:0] byte_address_lines_o,
  output      logic [nvram_host_pkg::DATA_W-1:0] byte_data_lines_o,
  output      logic                           byte_data_lines_oe_o,
  input  wire logic [nvram_host_pkg::DATA_W-1:0] byte_data_lines_i
);
  import nvram_host_pkg::*;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return (n < 1) ? CNT_ONE : CNT_W'(n);
  endfunction

  host_state_t      state;
  host_state_t      next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             is_write;
  logic [ADDR_W-1:0] cur_addr;
  logic             tally_busy;

  wire cnt_done   = (cnt == CNT_ONE);
  // no access while the wear counters are still being cleared after reset
  wire take_req   = (state == ST_IDLE) && req_valid_i && supply_ok_i && !srst_i &&
                    !tally_busy;
  // select stays low for max of active min and access time; write stretch fits well under max
  localparam int ACT_CYC = (CE_ACTIVE_CYC > ACCESS_CYC) ? CE_ACTIVE_CYC : ACCESS_CYC;
  localparam int WACT_CYC = (ACT_CYC > WE_PULSE_CYC + 1) ? ACT_CYC : WE_PULSE_CYC + 1;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_cnt   = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_ONE;
    case (state)
      ST_IDLE: begin
        if (take_req) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // address settled one cycle before the select fall
        next_state = ST_ACT;
        next_cnt   = is_write ? cyc(WACT_CYC) : cyc(ACT_CYC);
      end
      ST_ACT: begin
        if (is_write && WE_CONTROLLED) begin
          next_state = ST_WSTRB;
          next_cnt   = cnt - CNT_ONE;
        end else if (cnt_done) begin
          next_state = ST_PRE;
          next_cnt   = cyc(PRECHARGE_CYC);
        end
      end
      ST_WSTRB: begin
        if (cnt_done) begin
          next_state = ST_PRE;
          next_cnt   = cyc(PRECHARGE_CYC);
        end
      end
      ST_PRE: begin
        if (cnt_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  wire sel_low   = (next_state == ST_ACT) || (next_state == ST_WSTRB);
  // select-controlled write: strobe drops with the take, a cycle before select falls
  wire strobe_lo = (!WE_CONTROLLED && (next_state == ST_SETUP) && req_write_i) ||
                   (is_write && ((next_state == ST_WSTRB) ||
                   (!WE_CONTROLLED && sel_low)));
  wire oe_low    = !is_write && sel_low;
  wire drive_d   = (take_req && req_write_i) ||
                   (is_write && (state != ST_IDLE) && (next_state != ST_IDLE));
  wire sample    = (state == ST_ACT) && !is_write && cnt_done;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      cnt   <= CNT_ZERO;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      is_write <= 1'b0;
      cur_addr <= '0;
    end else if (take_req) begin
      is_write <= req_write_i;
      cur_addr <= req_addr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      chip_sel_n_o         <= 1'b1;
      write_strobe_n_o     <= 1'b1;
      out_drive_n_o        <= 1'b1;
      byte_data_lines_oe_o <= 1'b0;
      byte_data_lines_o    <= '0;
      byte_address_lines_o <= '0;
      req_ready_o          <= 1'b0;
      rsp_valid_o          <= 1'b0;
      rsp_rdata_o          <= '0;
      rsp_block_o          <= '0;
    end else begin
      chip_sel_n_o         <= !sel_low;
      write_strobe_n_o     <= !strobe_lo;
      out_drive_n_o        <= !oe_low;
      byte_data_lines_oe_o <= drive_d;
      if (take_req) begin
        byte_address_lines_o <= req_addr_i;
        byte_data_lines_o    <= req_wdata_i;
      end
      req_ready_o <= (next_state == ST_IDLE) && !take_req && !tally_busy;
      rsp_valid_o <= sample || ((state == ST_PRE) && cnt_done && is_write);
      if (sample) begin
        rsp_rdata_o <= byte_data_lines_i;
      end
      rsp_block_o <= cur_addr[ADDR_W-1 -: BLOCK_BITS];
    end
  end

  ////////////////////////////////////////////////////////////////
  nvram_row_tally #(
    .ROW_AW (ADDR_W - ROW_BYTES_LG2),
    .CNT_W  (16)
  ) u_tally (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .bump_i     (state == ST_SETUP),
    .bump_row_i (cur_addr[ADDR_W-1:ROW_BYTES_LG2]),
    .rd_row_i   (cur_addr[ADDR_W-1:ROW_BYTES_LG2]),
    .rd_count_o (rsp_row_wear_o),
    .clearing_o (tally_busy)
  );

  ////////////////////////////////////////////////////////////////
  logic [7:0] low_cnt;
  always_ff @(posedge clk_i) begin
    if (srst_i || chip_sel_n_o) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  logic [CNT_W-1:0] we_low_cnt;
  always_ff @(posedge clk_i) begin
    if (srst_i || write_strobe_n_o) begin
      we_low_cnt <= CNT_ZERO;
    end else if (we_low_cnt != {CNT_W{1'b1}}) begin
      we_low_cnt <= we_low_cnt + CNT_ONE;
    end
  end

  a_sel_max_low: assert property (@(posedge clk_i) disable iff (srst_i)
    low_cnt < 8'd40) else $error("select low too long");
  a_sel_min_low: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(chip_sel_n_o) |-> !chip_sel_n_o [*2]) else $error("select low too short");
  a_precharge: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(chip_sel_n_o) |-> chip_sel_n_o [*2]) else $error("precharge too short");
  a_no_drive_rd: assert property (@(posedge clk_i) disable iff (srst_i)
    !out_drive_n_o |-> !byte_data_lines_oe_o) else $error("bus contention");
  a_write_oe_hi: assert property (@(posedge clk_i) disable iff (srst_i)
    !write_strobe_n_o |-> out_drive_n_o) else $error("output enabled during write");
  // write access runs while both are low; data is launched at the take, before that
  a_data_stable: assert property (@(posedge clk_i) disable iff (srst_i)
    !write_strobe_n_o && !chip_sel_n_o |-> byte_data_lines_oe_o && $stable(byte_data_lines_o))
    else $error("write data moved");
  a_addr_stable: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(chip_sel_n_o) |-> $stable(byte_address_lines_o)) else $error("address not settled");
  a_strobe_width: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(write_strobe_n_o) |-> we_low_cnt >= CNT_W'(WE_PULSE_CYC))
    else $error("strobe too short");
  a_read_resp: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(chip_sel_n_o) && !out_drive_n_o |-> ##[1:2] rsp_valid_o)
    else $error("read response late");
endmodule

// File: hdl/nvram_host_pkg.sv
// constants for the latched parallel nonvolatile memory host controller
package nvram_host_pkg;
  localparam int ADDR_W        = 15;
  localparam int DATA_W        = 8;
  localparam int BLOCK_BITS    = 5;
  localparam int ROW_BYTES_LG2 = 2;
  localparam int CLK_PERIOD_NS = 50;
  // pin timing in ns
  localparam int T_CE_ACTIVE_MIN_NS = 70;
  localparam int T_CE_ACTIVE_MAX_NS = 2000;
  localparam int T_ACCESS_MAX_NS    = 70;
  localparam int T_PRECHARGE_MIN_NS = 60;
  localparam int T_WE_PULSE_MIN_NS  = 40;
  localparam int T_DATA_SETUP_NS    = 30;
  localparam int T_ADDR_HOLD_NS     = 10;
  // least times round up, access waits past the latest valid point
  localparam int CE_ACTIVE_CYC = (T_CE_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_MAX_CYC    = T_CE_ACTIVE_MAX_NS / CLK_PERIOD_NS;
  localparam int ACCESS_CYC    = (T_ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (T_PRECHARGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_PULSE_CYC  = (T_WE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DSETUP_CYC    = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_ACT   = 3'b011,
    ST_WSTRB = 3'b010,
    ST_PRE   = 3'b110
  } host_state_t;
endpackage

// File: hdl/nvram_row_tally.sv
// per-row access counters for endurance accounting
`timescale 1ns/100ps
module nvram_row_tally #(
  parameter int ROW_AW = 13,
  parameter int CNT_W  = 16
) (
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              bump_i,
  input  wire logic [ROW_AW-1:0] bump_row_i,
  input  wire logic [ROW_AW-1:0] rd_row_i,
  output      logic [CNT_W-1:0]  rd_count_o,
  output      logic              clearing_o
);
  logic [CNT_W-1:0] mem [2**ROW_AW];
  logic [CNT_W-1:0] bump_old;
  wire  [CNT_W-1:0] bump_new = bump_old + {{(CNT_W-1){1'b0}}, 1'b1};
  logic             bump_d;
  logic [ROW_AW-1:0] bump_row_d;
  logic [ROW_AW-1:0] clr_row;
  wire               clr_last = (clr_row == {ROW_AW{1'b1}});

  // read-modify-write over two cycles; host spacing keeps bumps far apart
  always_ff @(posedge clk_i) begin
    bump_old   <= mem[bump_row_i];
    bump_d     <= bump_i & ~srst_i;
    bump_row_d <= bump_row_i;
    if (clearing_o) begin
      mem[clr_row] <= '0;
    end else if (bump_d) begin
      mem[bump_row_d] <= bump_new;
    end
    rd_count_o <= mem[rd_row_i];
  end

  // ram has no reset: sweep one row per cycle after reset, host waits meanwhile
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clearing_o <= 1'b1;
      clr_row    <= '0;
    end else if (clearing_o) begin
      clearing_o <= !clr_last;
      clr_row    <= clr_row + {{(ROW_AW-1){1'b0}}, 1'b1};
    end
  end
endmodule

// File: testbench/latched_parallel_nvram_port_test.sv
// self-checking bench for the nonvolatile memory host controller
`timescale 1ns/100ps
module latched_parallel_nvram_port_test;
  import nvram_host_pkg::*;
  typedef struct packed {logic wr; logic [7:0] d; logic [4:0] blk; logic [15:0] wear;} note_t;
  logic        clk;
  logic        srst = 1'b1;
  logic        supply_ok = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [14:0] req_addr = '0;
  logic [7:0]  req_wdata = '0;
  logic        req_ready, rsp_valid, cs_n, we_n, oe_n, hoe;
  logic [7:0]  rsp_rdata, hd, dq;
  logic [4:0]  rsp_block;
  logic [14:0] addr, addr_ce;
  logic        ready_ce, valid_ce, cs_n_ce, we_n_ce, oe_n_ce, hoe_ce;
  logic [7:0]  rdata_ce, hd_ce, dq_ce;
  logic [4:0]  block_ce;
  logic [15:0] rsp_wear, wear_ce;
  int          viol_ce;
  int          wear [8192];
  int          viol, err_total = 0, check_count = 0, cs_falls = 0, n_req = 0, seed = 70;
  logic [7:0]  shadow [32768];
  note_t       q[$];
  note_t       nt;
  nvram_host #(.WE_CONTROLLED(1'b1)) nvram_host_i (
    .clk_i(clk), .srst_i(srst), .supply_ok_i(supply_ok), .req_valid_i(req_valid),
    .req_write_i(req_write), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
    .req_ready_o(req_ready), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata),
    .rsp_block_o(rsp_block), .rsp_row_wear_o(rsp_wear), .chip_sel_n_o(cs_n),
    .write_strobe_n_o(we_n), .out_drive_n_o(oe_n), .byte_address_lines_o(addr),
    .byte_data_lines_o(hd), .byte_data_lines_oe_o(hoe), .byte_data_lines_i(dq));
  nvram_dev_model nvram_dev_model_i (
    .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n), .byte_address_lines_i(addr),
    .hd_i(hd), .hoe_i(hoe), .byte_data_lines_o(dq), .viol_o(viol));
  // second host in select-controlled write mode runs in lockstep on the same requests
  nvram_host #(.WE_CONTROLLED(1'b0)) nvram_host_ce_i (
    .clk_i(clk), .srst_i(srst), .supply_ok_i(supply_ok), .req_valid_i(req_valid),
    .req_write_i(req_write), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
    .req_ready_o(ready_ce), .rsp_valid_o(valid_ce), .rsp_rdata_o(rdata_ce),
    .rsp_block_o(block_ce), .rsp_row_wear_o(wear_ce), .chip_sel_n_o(cs_n_ce),
    .write_strobe_n_o(we_n_ce), .out_drive_n_o(oe_n_ce), .byte_address_lines_o(addr_ce),
    .byte_data_lines_o(hd_ce), .byte_data_lines_oe_o(hoe_ce), .byte_data_lines_i(dq_ce));
  nvram_dev_model nvram_dev_model_ce_i (
    .cs_n_i(cs_n_ce), .we_n_i(we_n_ce), .oe_n_i(oe_n_ce), .byte_address_lines_i(addr_ce),
    .hd_i(hd_ce), .hoe_i(hoe_ce), .byte_data_lines_o(dq_ce), .viol_o(viol_ce));
  //////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // note the expectation first, then hold the request until taken
  task automatic do_req(input logic wr, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    wear[a[14:2]]++;
    q.push_back({wr, wr ? d : shadow[a], a[14:10], 16'(wear[a[14:2]])});
    if (wr) shadow[a] = d;
    do begin
      @(posedge clk);
      n++;
    end while (!(req_ready === 1'b1 && supply_ok === 1'b1) && n < 200);
    req_valid <= 1'b0;
    n_req++;
    if (n == 200) begin
      err_total++;
      close_out();
    end
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end
  always @(negedge cs_n) cs_falls++;
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) begin
      nt = q.pop_front();
      check(16'(rsp_block), 16'(nt.blk));
      check(16'(block_ce), 16'(nt.blk));
      check(rsp_wear, nt.wear);
      check(wear_ce, nt.wear);
      check({14'h0000, valid_ce, ready_ce}, {15'h0001, req_ready});
      if (!nt.wr) check(16'(rsp_rdata), 16'(nt.d));
      if (!nt.wr) check(16'(rdata_ce), 16'(nt.d));
    end
  end
  initial begin
    logic [14:0] a;
    logic [7:0]  d;
    int          n0;
    for (int i = 0; i < 32768; i++)
      shadow[i] = 8'(i ^ (i >> 7));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check({12'h000, cs_n, we_n, oe_n, hoe}, 16'h000e);
    check({12'h000, cs_n_ce, we_n_ce, oe_n_ce, hoe_ce}, 16'h000e);
    // wear counters clear one row per cycle before the first request is taken
    while (req_ready !== 1'b1) @(posedge clk);
    for (int k = 0; k < 20; k++) begin
      a = (k == 0) ? 15'h0000 : (k == 1) ? 15'h7fff : 15'($random(seed));
      d = 8'($random(seed));
      do_req(1'b1, a, d);
      do_req(1'b0, a, 8'h00);
      do_req(1'b0, a ^ 15'h0004, 8'h00);
    end
    repeat (12) @(posedge clk);
    n0 = cs_falls;
    supply_ok <= 1'b0;
    fork
      do_req(1'b0, 15'h7ffc, 8'h00);
      begin
        repeat (20) @(posedge clk);
        check(16'(cs_falls - n0), 16'h0000);
        supply_ok <= 1'b1;
      end
    join
    repeat (20) @(posedge clk);
    check(16'(cs_falls), 16'(n_req));
    check(16'(q.size()), 16'h0000);
    check(16'(viol), 16'h0000);
    check(16'(viol_ce), 16'h0000);
    close_out();
  end
endmodule

// File: testbench/nvram_dev_model.sv
// behavioural byte-wide nonvolatile memory on the far side of the host
`timescale 1ns/100ps
module nvram_dev_model
  import nvram_host_pkg::*;
#(
  parameter int ACC_NS = 70
) (
  input  wire logic        cs_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [14:0] byte_address_lines_i,
  input  wire logic [7:0]  hd_i,
  input  wire logic        hoe_i,
  output      logic [7:0]  byte_data_lines_o,
  output      int          viol_o
);
  logic [7:0]  mem [32768];
  logic [14:0] lat;
  logic        wr = 1'b0;
  logic        vld = 1'b0;
  logic        run = 1'b0;
  logic [7:0]  last = 8'h00;
  realtime     tf, tr, tw, td;
  wire         drv = !cs_n_i && !oe_n_i && vld && !wr;
  initial begin
    viol_o = 0;
    tr = -1.0e3;
    for (int i = 0; i < 32768; i++)
      mem[i] = 8'(i ^ (i >> 7));
  end
  //////////////////////////////////////////////////////////////
  always @(negedge cs_n_i) begin
    if ($realtime - tr < T_PRECHARGE_MIN_NS) viol_o++;
    tf = $realtime;
    lat = byte_address_lines_i;
    wr = !we_n_i;
    run = 1'b1;
    #(ACC_NS);
    vld = !cs_n_i;
  end
  always @(negedge we_n_i) begin
    tw = $realtime;
    if (!cs_n_i) wr = 1'b1;
  end
  always @(hd_i) td = $realtime;
  always @(posedge we_n_i) if (run && $realtime - tw < T_WE_PULSE_MIN_NS) viol_o++;
  // host data reg taken, the bus may already be released in the same step
  always @(posedge we_n_i or posedge cs_n_i) begin
    if (wr) begin
      if ($realtime - td < T_DATA_SETUP_NS) viol_o++;
      mem[lat] = hd_i;
      wr = 1'b0;
    end
  end
  always @(posedge cs_n_i) begin
    tr = $realtime;
    vld = 1'b0;
    if (run && (tr - tf < T_CE_ACTIVE_MIN_NS || tr - tf > T_CE_ACTIVE_MAX_NS)) viol_o++;
    run = 1'b0;
  end
  // released bus shows the inverse of its last level, no pull
  always @* begin
    if (hoe_i)
      byte_data_lines_o = hd_i;
    else if (drv)
      byte_data_lines_o = mem[lat];
    else
      byte_data_lines_o = ~last;
  end
  always @(byte_data_lines_o) if (hoe_i || drv) last = byte_data_lines_o;
endmodule
